// ==== rtl/tdl_tamper_detect.sv ====
// tdl_tamper_detect: two-channel tamper detection with flags and interrupt
//
// Function
// - two independent tamper channels, each with its own flag gated by its enable.
// - both flags are read back from the event flag register at 0x0f.
// - channel a and b configuration sits at 0x14 and 0x15.
// - enable bit 1 activates detection, 0 keeps the channel inactive.
// - an enabled channel sets its flag to 1 when its tamper condition occurs.
// - flags are read-only and clear only while software holds enable at 0.
// - with irq enable at 1 a tamper event pulls the active-low interrupt low.
// - on battery the interrupt is raised only when alarm-in-backup is 1.
// - switch style 1 is normally open (closing trips), 0 normally closed.
// - polarity 1 trips on the pin going high, 0 on the pin going low.
// - an enabled channel's flag sets at once, except a normally-closed one with sampling selected, which waits for the tick.
// - normally-closed channels choose 1 Hz sampling or continuous watching.
`timescale 1ns/1ps
module tdl_tamper_detect #(
	parameter int SAMPLE_CYCLES = tdl_pkg::SAMPLE_CYCLES
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic intrusion_in_a_i,
	input wire logic intrusion_in_b_i,
	input wire logic on_battery_i,
	input wire logic alarm_in_backup_en_i,
	output logic irq_n_o
);
	tdl_pkg::tdl_req_s req;
	tdl_pkg::tdl_cfg_s cfg_r [2];
	logic [1:0] pin_meta_r;
	logic [1:0] pin_sync_r;
	logic [1:0] bat_sync_r;
	logic [1:0] flag_r;
	logic [1:0] trip;
	logic [1:0] event_now;
	logic [31:0] tick_cnt_r;
	logic tick;
	logic irq_want;

	assign req = '{addr: reg_addr_i, wr: reg_wr_i, rd: reg_rd_i,
		wdata: reg_wdata_i};

	// pack a configuration struct into its register byte
	function automatic logic [7:0] cfg_to_byte(input tdl_pkg::tdl_cfg_s c);
		logic [7:0] b;
		b = 8'h00;
		b[tdl_pkg::CFG_EN_BIT] = c.intrusion_en;
		b[tdl_pkg::CFG_IRQ_EN_BIT] = c.intrusion_irq_en;
		b[tdl_pkg::CFG_STYLE_BIT] = c.switch_style;
		b[tdl_pkg::CFG_POL_BIT] = c.trigger_polarity;
		b[tdl_pkg::CFG_SAMPLE_BIT] = c.sample_select;
		return b;
	endfunction

	// unpack a written byte; unused bits are dropped and read as zero
	function automatic tdl_pkg::tdl_cfg_s byte_to_cfg(input logic [7:0] b);
		tdl_pkg::tdl_cfg_s c;
		c.intrusion_en = b[tdl_pkg::CFG_EN_BIT];
		c.intrusion_irq_en = b[tdl_pkg::CFG_IRQ_EN_BIT];
		c.switch_style = b[tdl_pkg::CFG_STYLE_BIT];
		c.trigger_polarity = b[tdl_pkg::CFG_POL_BIT];
		c.sample_select = b[tdl_pkg::CFG_SAMPLE_BIT];
		return c;
	endfunction

	// pins and battery status come from outside the clock domain
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			pin_meta_r <= 2'h0;
			pin_sync_r <= 2'h0;
			bat_sync_r <= 2'h0;
		end
		else
		begin
			pin_meta_r <= {intrusion_in_b_i, intrusion_in_a_i};
			pin_sync_r <= pin_meta_r;
			bat_sync_r <= {bat_sync_r[0], on_battery_i};
		end
	end

	// free-running 1 Hz sample tick shared by both channels
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			tick_cnt_r <= 32'h0;
		else if (tick)
			tick_cnt_r <= 32'h0;
		else
			tick_cnt_r <= tick_cnt_r + 32'h1;
	end
	assign tick = (tick_cnt_r == 32'(SAMPLE_CYCLES - 1));

	// configuration writes land at the per-channel addresses
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			cfg_r[0] <= byte_to_cfg(tdl_pkg::CFG_RESET);
			cfg_r[1] <= byte_to_cfg(tdl_pkg::CFG_RESET);
		end
		else if (req.wr && req.addr == tdl_pkg::ADDR_CFG_A)
			cfg_r[0] <= byte_to_cfg(req.wdata);
		else if (req.wr && req.addr == tdl_pkg::ADDR_CFG_B)
			cfg_r[1] <= byte_to_cfg(req.wdata);
	end

	// per-channel trip condition and sticky flag
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_chan
			// the pin is at the tripped level when it equals the polarity;
			// both switch styles trip to that level, style only picks sampling
			assign trip[ch] = (pin_sync_r[ch] ==
				cfg_r[ch].trigger_polarity);
			// normally-open is always watched; normally-closed may be sampled
			assign event_now[ch] = cfg_r[ch].intrusion_en && trip[ch] &&
				(cfg_r[ch].switch_style || !cfg_r[ch].sample_select ||
				tick);

			// set wins over the enable-low clear; no write to the flag register clears it
			always_ff @(posedge clock_i)
			begin
				if (rst_i)
					flag_r[ch] <= 1'b0;
				else if (event_now[ch])
					flag_r[ch] <= 1'b1;
				else if (!cfg_r[ch].intrusion_en)
					flag_r[ch] <= 1'b0;
			end

			chk_flag_sets_now: assert property (@(posedge clock_i)
				disable iff (rst_i)
				event_now[ch] |=> flag_r[ch])
				else $error("flag did not set after tamper event");
			// a flag seen set with its enable high must still be set one
			// edge later; checking the level avoids tripping on the rise
			chk_flag_holds: assert property (@(posedge clock_i)
				disable iff (rst_i)
				$past(flag_r[ch]) && $past(cfg_r[ch].intrusion_en)
				|-> flag_r[ch])
				else $error("flag changed while channel enabled");
			chk_flag_needs_en: assert property (@(posedge clock_i)
				disable iff (rst_i)
				$rose(flag_r[ch]) |-> $past(cfg_r[ch].intrusion_en))
				else $error("flag set on a disabled channel");
			chk_flag_clears: assert property (@(posedge clock_i)
				disable iff (rst_i)
				!cfg_r[ch].intrusion_en && !event_now[ch]
				|=> !flag_r[ch])
				else $error("flag not cleared by enable low");
			chk_sampled_wait: assert property (@(posedge clock_i)
				disable iff (rst_i)
				$rose(flag_r[ch]) && !$past(cfg_r[ch].switch_style) &&
				$past(cfg_r[ch].sample_select) |-> $past(tick))
				else $error("sampled channel tripped off the tick");
			chk_pol_match: assert property (@(posedge clock_i)
				disable iff (rst_i)
				$rose(flag_r[ch]) |-> $past(pin_sync_r[ch]) ==
				$past(cfg_r[ch].trigger_polarity))
				else $error("flag set with pin at idle level");
		end
	endgenerate

	// interrupt from any flagged channel with its interrupt enabled;
	// on battery it also needs alarm-in-backup
	assign irq_want = ((flag_r[0] && cfg_r[0].intrusion_irq_en) ||
		(flag_r[1] && cfg_r[1].intrusion_irq_en)) &&
		(!bat_sync_r[1] || alarm_in_backup_en_i);

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			irq_n_o <= 1'b1;
		else
			irq_n_o <= !irq_want;
	end

	sequence s_flag_with_irq_en;
		flag_r[0] && cfg_r[0].intrusion_irq_en;
	endsequence

	chk_irq_assert: assert property (@(posedge clock_i) disable iff (rst_i)
		s_flag_with_irq_en and !bat_sync_r[1] |=> !irq_n_o)
		else $error("interrupt missing for flagged channel");
	chk_irq_backup: assert property (@(posedge clock_i) disable iff (rst_i)
		bat_sync_r[1] && !alarm_in_backup_en_i |=> irq_n_o)
		else $error("interrupt raised on battery without backup enable");

	// register read data, captured on the read strobe
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			reg_rdata_o <= 8'h00;
		else if (req.rd)
		begin
			case (req.addr)
				tdl_pkg::ADDR_FLAGS:
				begin
					reg_rdata_o <= 8'h00;
					reg_rdata_o[tdl_pkg::FLAG_A_BIT] <= flag_r[0];
					reg_rdata_o[tdl_pkg::FLAG_B_BIT] <= flag_r[1];
				end
				tdl_pkg::ADDR_CFG_A: reg_rdata_o <= cfg_to_byte(cfg_r[0]);
				tdl_pkg::ADDR_CFG_B: reg_rdata_o <= cfg_to_byte(cfg_r[1]);
				default: reg_rdata_o <= 8'h00;
			endcase
		end
	end

	chk_flag_readback: assert property (@(posedge clock_i) disable iff (rst_i)
		req.rd && req.addr == tdl_pkg::ADDR_FLAGS
		|=> reg_rdata_o[tdl_pkg::FLAG_A_BIT] == $past(flag_r[0]))
		else $error("flag register read returned wrong flag");
endmodule

// ==== shared/tdl_pkg.sv ====
// tdl_pkg: register map, field layout and timing for the tamper detect logic
package tdl_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_FLAGS = 8'h0f;
	localparam logic [7:0] ADDR_CFG_A = 8'h14;
	localparam logic [7:0] ADDR_CFG_B = 8'h15;
	// channel configuration register fields
	localparam int CFG_EN_BIT = 7;
	localparam int CFG_IRQ_EN_BIT = 6;
	localparam int CFG_STYLE_BIT = 5;
	localparam int CFG_POL_BIT = 4;
	localparam int CFG_SAMPLE_BIT = 3;
	// event flag register fields
	localparam int FLAG_A_BIT = 3;
	localparam int FLAG_B_BIT = 2;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// sampling period for normally-closed sampled mode
	localparam int CLK_HZ = 25000000;
	localparam int SAMPLE_HZ = 1;
	localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;

	typedef struct packed {
		logic intrusion_en;
		logic intrusion_irq_en;
		logic switch_style;
		logic trigger_polarity;
		logic sample_select;
	} tdl_cfg_s;

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} tdl_req_s;
endpackage

// ==== bench/tdl_switch_model.sv ====
// tdl_switch_model: behavioural tamper switch wired to one intrusion pin
`timescale 1ns/1ps
module tdl_switch_model (
	input wire logic trip_i,
	input wire logic polarity_i,
	output logic pin_o
);
	// rest level is the inverse of the trip level, so the pin never floats
	assign pin_o = trip_i ? polarity_i : ~polarity_i;
endmodule

// ==== bench/tb_tamper_detect_logic.sv ====
// tb_tamper_detect_logic: register-level tests of the tamper detect block
`timescale 1ns/1ps
module tb_tamper_detect_logic;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [7:0] reg_rdata_o;
	logic trip_a = 1'b0;
	logic trip_b = 1'b0;
	logic pol_a = 1'b1;
	logic pol_b = 1'b0;
	logic pin_a;
	logic pin_b;
	logic on_battery_i = 1'b0;
	logic bkp_en = 1'b0;
	logic irq_n_o;
	int n_mismatch = 0;
	int comparisons = 0;

	// 25 MHz clock
	always #20 clock_i = ~clock_i;

	tdl_switch_model u_sw_a (.trip_i(trip_a), .polarity_i(pol_a),
		.pin_o(pin_a));
	tdl_switch_model u_sw_b (.trip_i(trip_b), .polarity_i(pol_b),
		.pin_o(pin_b));

	// short sampling period keeps the sampled-mode test brief
	tdl_tamper_detect #(.SAMPLE_CYCLES(8)) u_dut (
		.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .intrusion_in_a_i(pin_a),
		.intrusion_in_b_i(pin_b), .on_battery_i(on_battery_i),
		.alarm_in_backup_en_i(bkp_en), .irq_n_o(irq_n_o)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// inputs change at the falling edge, strobes last one cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge clock_i);
		reg_wr_i = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clock_i);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge clock_i);
		reg_rd_i = 1'b0;
		check(reg_rdata_o, exp);
	endtask

	task automatic irq(input logic exp);
		check({7'h00, irq_n_o}, {7'h00, exp});
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge clock_i);
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		int i;
		idle(12);
		rst_i = 1'b0;
		// map, reset values, unused bits and an unmapped place
		rd(8'h0f, 8'h00);
		rd(8'h14, 8'h00);
		wr(8'h14, 8'h7f);
		wr(8'h15, 8'h7f);
		wr(8'h3c, 8'hff);
		rd(8'h14, 8'h78);
		rd(8'h15, 8'h78);
		rd(8'h3c, 8'h00);
		$display("test map done");
		// a disabled channel ignores its pin
		trip_a = 1'b1;
		idle(6);
		rd(8'h0f, 8'h00);
		irq(1'b1);
		trip_a = 1'b0;
		$display("test disabled done");
		// configure with enable low first, then enable and trip
		wr(8'h14, 8'h50);
		wr(8'h14, 8'hd0);
		trip_a = 1'b1;
		idle(5);
		rd(8'h0f, 8'h08);
		irq(1'b0);
		trip_a = 1'b0;
		wr(8'h0f, 8'h00);
		idle(5);
		rd(8'h0f, 8'h08);
		$display("test detect done");
		// on battery the interrupt needs alarm-in-backup
		on_battery_i = 1'b1;
		idle(5);
		irq(1'b1);
		bkp_en = 1'b1;
		idle(3);
		irq(1'b0);
		on_battery_i = 1'b0;
		bkp_en = 1'b0;
		$display("test battery done");
		// flags read before the enable is dropped, which clears them
		rd(8'h0f, 8'h08);
		wr(8'h14, 8'h50);
		rd(8'h0f, 8'h00);
		irq(1'b1);
		// channel b normally open to ground, channel a stays clear
		wr(8'h15, 8'h60);
		wr(8'h15, 8'he0);
		trip_b = 1'b1;
		idle(5);
		rd(8'h0f, 8'h04);
		irq(1'b0);
		trip_b = 1'b0;
		wr(8'h15, 8'h00);
		$display("test channel b done");
		// normally closed, sampled: trips on a sampling tick
		pol_a = 1'b0;
		wr(8'h14, 8'h48);
		wr(8'h14, 8'hc8);
		trip_a = 1'b1;
		for (i = 0; i < 40 && irq_n_o !== 1'b0; i++)
			@(negedge clock_i);
		if (irq_n_o !== 1'b0)
		begin
			n_mismatch++;
			final_report();
		end
		rd(8'h0f, 8'h08);
		$display("test sampled done");
		final_report();
	end
endmodule
